/* File: include/ppl_params.svh */
// Constants of the process loop configuration block: register map,
// field limits, analog scaling codes and timing.
// Assumes 12-bit ADC codes where 12'hfff is 10 V or 20 mA.
`ifndef PPL_PARAMS_SVH
`define PPL_PARAMS_SVH

// Register byte addresses on the Avalon-MM slave.
`define PPL_REG_CTRL    6'h00
`define PPL_REG_SETPT   6'h04
`define PPL_REG_STBY    6'h08
`define PPL_REG_WAKE    6'h0c
`define PPL_REG_RELAY   6'h10
`define PPL_REG_STATUS  6'h14
`define PPL_REG_CLEAR   6'h18
`define PPL_REG_ENABLE  6'h1c
`define PPL_REG_STATE   6'h20
`define PPL_REG_FBK     6'h24
`define PPL_REG_CMD     6'h28
`define PPL_REG_RATED   6'h2c
`define PPL_REG_AIN     6'h30

// Percent values are held in tenths: 10'h3e8 is 100.0 %.
`define PPL_PCT_FULL    10'h3e8
`define PPL_WAKE_RST    10'h032
`define PPL_STBY_MAX    10'h258
`define PPL_RATED_RST   12'h064

// Analog input codes.
`define PPL_ADC_FULL    12'hfff
`define PPL_ADC_4MA     12'h333
`define PPL_ADC_SPAN420 12'hccc
`define PPL_ADC_3MA     12'h266
`define PPL_DC_FULL     12'h3e8
`define PPL_THERM_TRIP  12'h5dc
`define PPL_THERM_RESET 12'h3e8

// Standby dwell is counted in steps of 0.1 s.
`define PPL_CLK_NS      10
`define PPL_TICK_NS     100000000
`define PPL_TICK_CYCLES (`PPL_TICK_NS / `PPL_CLK_NS)

`endif

/* File: include/ppl_pkg.sv */
// Types of the process loop configuration block.
// Assumes ppl_params.svh supplies the numeric constants.
package ppl_pkg;
  typedef enum logic [1:0] {
    PPL_DIRECT       = 2'h0,
    PPL_INVERSE      = 2'h1,
    PPL_DIRECT_WAKE  = 2'h2,
    PPL_REVERSE_WAKE = 2'h3
  } ppl_sense_t;

  typedef enum logic [2:0] {
    PPL_FB_AIN2  = 3'h0,
    PPL_FB_AIN1  = 3'h1,
    PPL_FB_CURR  = 3'h2,
    PPL_FB_DCBUS = 3'h3,
    PPL_FB_DIFF  = 3'h4,
    PPL_FB_MAX   = 3'h5
  } ppl_fb_src_t;

  typedef enum logic [2:0] {
    PPL_FMT_V010  = 3'h0,
    PPL_FMT_A020  = 3'h1,
    PPL_FMT_T420  = 3'h2,
    PPL_FMT_R420  = 3'h3,
    PPL_FMT_T204  = 3'h4,
    PPL_FMT_R204  = 3'h5,
    PPL_FMT_THERM = 3'h6
  } ppl_fmt_t;

  typedef enum logic [1:0] {
    PPL_ST_RUN  = 2'b01,
    PPL_ST_STBY = 2'b10
  } ppl_stby_t;

  typedef struct packed {
    ppl_fmt_t    fmt;
    ppl_fb_src_t fb_src;
    logic        sp_src;
    ppl_sense_t  sense;
    logic        pi_mode;
  } ppl_ctrl_t;

  typedef struct packed {
    logic wake;
    logic standby;
    logic therm;
    logic loss;
  } ppl_evt_t;

  typedef struct packed {
    logic [5:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } ppl_avmm_req_t;
endpackage : ppl_pkg

/* File: verilog/ppl_scale.sv */
// Linear scaling of a raw code into tenths of a percent, clamped to 100.0 %.
// Purely combinational; the caller registers the result.
`timescale 1ns/10ps
`include "ppl_params.svh"
module ppl_scale (
  // Raw value and range
  input  wire logic [11:0] value,
  input  wire logic [11:0] base,
  input  wire logic [11:0] span,
  input  wire logic        invert,
  // Result
  output logic      [9:0]  scaled
);
  wire [11:0] lifted = (value > base) ? value - base : 12'h000;
  wire [23:0] prod   = 24'(lifted) * 24'(`PPL_PCT_FULL);
  // A zero span would divide by zero, so it reads as an empty signal.
  wire [23:0] quot   = (span == 12'h000) ? 24'h000000 : prod / 24'(span);
  wire [9:0]  pct    = (quot > 24'(`PPL_PCT_FULL)) ? `PPL_PCT_FULL : quot[9:0];

  assign scaled = invert ? `PPL_PCT_FULL - pct : pct;
endmodule : ppl_scale

/* File: verilog/ppl_hyst.sv */
// Comparator with hysteresis: sets above hi, clears at or below lo.
// Assumes lo is not above hi; between them the last state holds.
`timescale 1ns/10ps
module ppl_hyst (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Comparison
  input  wire logic [11:0] value,
  input  wire logic [11:0] hi,
  input  wire logic [11:0] lo,
  output logic             above_q
);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      above_q <= 1'b0;
    end else if (value > hi) begin
      above_q <= 1'b1;
    end else if (value <= lo) begin
      above_q <= 1'b0;
    end
  end
endmodule : ppl_hyst

/* File: verilog/ppl_loop_cfg.sv */
// Process PI loop configuration and supervision with an Avalon-MM slave.
// Assumes ADC codes, motor current and bus voltage arrive on clk, and an
// external PI core takes pi_error and returns its raw output.
// What this block does
// - Sense 0 direct: falling feedback raises demand.
// - Sense 1 inverse: falling feedback lowers demand.
// - Sense 2 direct, full output on wake.
// - Sense 3 forces full output on wake.
// - Setpoint from digital preset or analog 1.
// - Digital setpoint 0.0 to 100.0 percent is reference.
// - Feedback from analog 2, analog 1, current.
// - Feedback 3 maps 0-1000 V to percent.
// - Feedback 4 is analog 1 minus 2, floored.
// - Feedback 5 takes larger analog input.
// - Analog 2 accepts 0-10 V and 0-20 mA.
// - Run formats select preset speed below 3 mA.
// - Thermistor trips above 1.5k, resets at 1k.
// - Standby after timed dwell at minimum speed.
// - PI mode wakes when error exceeds threshold.
// - Relay comparison uses programmable hysteresis band.
`timescale 1ns/10ps
`include "ppl_params.svh"
module ppl_loop_cfg
  import ppl_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `PPL_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          reset_n,
  // Avalon-MM slave
  input  wire ppl_avmm_req_t avs,
  output logic [31:0]        avs_readdata,
  output logic               avs_waitrequest,
  // Process inputs
  input  wire logic [11:0]   ain1_code,
  input  wire logic [11:0]   ain2_code,
  input  wire logic [11:0]   motor_current,
  input  wire logic [11:0]   dc_bus_volts,
  input  wire logic          at_min_speed,
  input  wire logic [11:0]   pi_core_out,
  // PI core side
  output logic [11:0]        pi_error,
  output logic [9:0]         pi_setpoint,
  output logic [9:0]         pi_feedback,
  output logic [9:0]         pi_out,
  output logic               pi_preset,
  // Supervision
  output logic               standby,
  output logic               preset_speed1_sel,
  output logic               loop_loss_fault,
  output logic               thermistor_trip,
  output logic               relay_out,
  output logic               irq
);
  ppl_ctrl_t   ctrl_q;
  ppl_evt_t    status_q, enable_q, evt;
  ppl_stby_t   st_q, st_d;
  logic [9:0]  setpt_q, stby_time_q, wake_lvl_q, relay_thr_q, relay_hys_q;
  logic [11:0] rated_q, error_q, error_d;
  logic [9:0]  sp_q, fb_q, fb_d, out_q, out_d, a1_rb_q, a2_rb_q, tenth_q;
  logic [31:0] rdata_q, tick_q;
  logic        wait_q, preset_q, loss_q, therm_q, run_loss_q, irq_q;
  logic        relay_q, therm_hot;

  // Bus decode. A request is answered one cycle after it is seen.
  wire        req       = avs.read | avs.write;
  wire        accept    = req & ~wait_q;
  wire        wr        = accept & avs.write;
  wire [31:0] wd        = avs.writedata;
  wire        wr_ctrl   = wr & (avs.address == `PPL_REG_CTRL);
  wire        wr_setpt  = wr & (avs.address == `PPL_REG_SETPT);
  wire        wr_stby   = wr & (avs.address == `PPL_REG_STBY);
  wire        wr_wake   = wr & (avs.address == `PPL_REG_WAKE);
  wire        wr_relay  = wr & (avs.address == `PPL_REG_RELAY);
  wire        wr_clear  = wr & (avs.address == `PPL_REG_CLEAR);
  wire        wr_enable = wr & (avs.address == `PPL_REG_ENABLE);
  wire        wr_cmd    = wr & (avs.address == `PPL_REG_CMD);
  wire        wr_rated  = wr & (avs.address == `PPL_REG_RATED);
  wire        fault_rst = wr_cmd & wd[0];
  wire [9:0]  wd_pct    = (wd[9:0] > `PPL_PCT_FULL) ? `PPL_PCT_FULL : wd[9:0];
  wire [9:0]  wd_hi_pct = (wd[25:16] > `PPL_PCT_FULL) ? `PPL_PCT_FULL : wd[25:16];
  wire [9:0]  wd_stby   = (wd[9:0] > `PPL_STBY_MAX) ? `PPL_STBY_MAX : wd[9:0];
  wire [3:0]  clear_bits = wr_clear ? wd[3:0] : 4'h0;

  // Analog input 2 format decode.
  wire fmt_trip  = (ctrl_q.fmt == PPL_FMT_T420) | (ctrl_q.fmt == PPL_FMT_T204);
  wire fmt_run   = (ctrl_q.fmt == PPL_FMT_R420) | (ctrl_q.fmt == PPL_FMT_R204);
  wire fmt_inv   = (ctrl_q.fmt == PPL_FMT_T204) | (ctrl_q.fmt == PPL_FMT_R204);
  wire fmt_therm = (ctrl_q.fmt == PPL_FMT_THERM);
  wire fmt_live  = fmt_trip | fmt_run;
  wire a2_low    = ain2_code < `PPL_ADC_3MA;
  wire [11:0] a2_base = fmt_live ? `PPL_ADC_4MA : 12'h000;
  wire [11:0] a2_span = fmt_live ? `PPL_ADC_SPAN420 : `PPL_ADC_FULL;

  // Both plain formats use the full code range: 10 V and 20 mA alike.
  wire [9:0] a1_pct, a2_pct, cur_pct;
  ppl_scale u_scale_ain1 (
    .value  (ain1_code),
    .base   (12'h000),
    .span   (`PPL_ADC_FULL),
    .invert (1'b0),
    .scaled (a1_pct)
  );
  ppl_scale u_scale_ain2 (
    .value  (ain2_code),
    .base   (a2_base),
    .span   (a2_span),
    .invert (fmt_inv),
    .scaled (a2_pct)
  );
  ppl_scale u_scale_curr (
    .value  (motor_current),
    .base   (12'h000),
    .span   (rated_q),
    .invert (1'b0),
    .scaled (cur_pct)
  );
  // One volt is one tenth of a percent up to the top of the scale.
  wire [9:0] dc_pct = (dc_bus_volts > `PPL_DC_FULL) ? `PPL_PCT_FULL
                                                     : dc_bus_volts[9:0];

  // Feedback selection; the two unused codes fall back to analog 2.
  wire       a1_big = a1_pct > a2_pct;
  always_comb begin
    unique case (ctrl_q.fb_src)
      PPL_FB_AIN2:  fb_d = a2_pct;
      PPL_FB_AIN1:  fb_d = a1_pct;
      PPL_FB_CURR:  fb_d = cur_pct;
      PPL_FB_DCBUS: fb_d = dc_pct;
      PPL_FB_DIFF:  fb_d = a1_big ? a1_pct - a2_pct : 10'h000;
      PPL_FB_MAX:   fb_d = a1_big ? a1_pct : a2_pct;
      default:      fb_d = a2_pct;
    endcase
  end

  wire [9:0]  sp_d    = ctrl_q.sp_src ? a1_pct : setpt_q;
  wire        inverse = ctrl_q.sense[0];
  wire [11:0] e_dir   = {2'b00, sp_d} - {2'b00, fb_d};
  wire [11:0] e_inv   = {2'b00, fb_d} - {2'b00, sp_d};
  assign error_d = inverse ? e_inv : e_dir;

  // Standby dwell and wake decision.
  wire stby_en   = stby_time_q != 10'h000;
  wire dwelling  = (st_q == PPL_ST_RUN) & stby_en & at_min_speed;
  wire tick      = tick_q == (TICK_CYCLES - 32'h1);
  wire enter     = dwelling & (tenth_q >= stby_time_q);
  wire err_big   = $signed(error_d) > $signed({2'b00, wake_lvl_q});
  wire wake_cond = ctrl_q.pi_mode ? err_big : ~at_min_speed;
  wire wake      = (st_q == PPL_ST_STBY) & (wake_cond | ~stby_en);
  wire force_fw  = wake & ctrl_q.sense[1];

  always_comb begin
    unique case (st_q)
      PPL_ST_RUN:  st_d = enter ? PPL_ST_STBY : PPL_ST_RUN;
      PPL_ST_STBY: st_d = wake ? PPL_ST_RUN : PPL_ST_STBY;
      default:     st_d = PPL_ST_RUN;
    endcase
  end

  // The core output is clamped; a negative raw value means no demand.
  wire [9:0] core_pct = pi_core_out[11] ? 10'h000
                      : (pi_core_out > 12'(`PPL_PCT_FULL)) ? `PPL_PCT_FULL
                      : pi_core_out[9:0];
  assign out_d = force_fw ? `PPL_PCT_FULL
               : (st_q == PPL_ST_STBY && !wake) ? 10'h000 : core_pct;

  // Trips and loss handling. A trip holds until a fault reset with the
  // cause gone, so a reset during the fault does not release it.
  wire loss_now  = fmt_trip & a2_low;
  wire therm_now = fmt_therm & therm_hot;
  ppl_hyst u_therm (
    .clk     (clk),
    .reset_n (reset_n),
    .value   (ain2_code),
    .hi      (`PPL_THERM_TRIP),
    .lo      (`PPL_THERM_RESET),
    .above_q (therm_hot)
  );

  // Relay band sits below the threshold so zero hysteresis is a plain compare.
  wire [9:0] relay_lo = (relay_thr_q > relay_hys_q) ? relay_thr_q - relay_hys_q : 10'h000;
  ppl_hyst u_relay (
    .clk     (clk),
    .reset_n (reset_n),
    .value   ({2'b00, fb_q}),
    .hi      ({2'b00, relay_thr_q}),
    .lo      ({2'b00, relay_lo}),
    .above_q (relay_q)
  );

  assign evt = '{wake: wake, standby: enter,
                 therm: therm_now & ~therm_q, loss: loss_now & ~loss_q};
  wire ppl_evt_t status_d = evt | (status_q & ~clear_bits);  // set wins over clear

  wire [31:0] rdata_d =
      (avs.address == `PPL_REG_CTRL)   ? {22'h000000, ctrl_q} :
      (avs.address == `PPL_REG_SETPT)  ? {22'h000000, setpt_q} :
      (avs.address == `PPL_REG_STBY)   ? {22'h000000, stby_time_q} :
      (avs.address == `PPL_REG_WAKE)   ? {22'h000000, wake_lvl_q} :
      (avs.address == `PPL_REG_RELAY)  ? {6'h00, relay_hys_q, 6'h00, relay_thr_q} :
      (avs.address == `PPL_REG_STATUS) ? {28'h0000000, status_q} :
      (avs.address == `PPL_REG_ENABLE) ? {28'h0000000, enable_q} :
      (avs.address == `PPL_REG_STATE)  ? {26'h0000000, therm_hot, run_loss_q, therm_q,
                                          loss_q, relay_q, st_q == PPL_ST_STBY} :
      (avs.address == `PPL_REG_FBK)    ? {6'h00, sp_q, 6'h00, fb_q} :
      (avs.address == `PPL_REG_RATED)  ? {20'h00000, rated_q} :
      (avs.address == `PPL_REG_AIN)    ? {6'h00, a2_rb_q, 6'h00, a1_rb_q} : 32'h00000000;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h00000000;
    end else begin
      wait_q  <= ~(req & wait_q);
      rdata_q <= (req & wait_q) ? rdata_d : rdata_q;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q      <= '{fmt: PPL_FMT_V010, fb_src: PPL_FB_AIN2, sp_src: 1'b0,
                       sense: PPL_DIRECT, pi_mode: 1'b0};
      setpt_q     <= 10'h000;
      stby_time_q <= 10'h000;
      wake_lvl_q  <= `PPL_WAKE_RST;
      relay_thr_q <= 10'h000;
      relay_hys_q <= 10'h000;
      rated_q     <= `PPL_RATED_RST;
      enable_q    <= 4'h0;
    end else begin
      if (wr_ctrl)   ctrl_q      <= ppl_ctrl_t'(wd[9:0]);
      if (wr_setpt)  setpt_q     <= wd_pct;
      if (wr_stby)   stby_time_q <= wd_stby;
      if (wr_wake)   wake_lvl_q  <= wd_pct;
      if (wr_relay)  relay_thr_q <= wd_pct;
      if (wr_relay)  relay_hys_q <= wd_hi_pct;
      if (wr_rated)  rated_q     <= wd[11:0];
      if (wr_enable) enable_q    <= wd[3:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q    <= PPL_ST_RUN;
      tick_q  <= 32'h00000000;
      tenth_q <= 10'h000;
    end else begin
      st_q    <= st_d;
      tick_q  <= (!dwelling || tick) ? 32'h00000000 : tick_q + 32'h1;
      tenth_q <= !dwelling ? 10'h000
               : (tick && tenth_q != `PPL_STBY_MAX) ? tenth_q + 10'h1 : tenth_q;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sp_q       <= 10'h000;
      fb_q       <= 10'h000;
      error_q    <= 12'h000;
      out_q      <= 10'h000;
      preset_q   <= 1'b0;
      a1_rb_q    <= 10'h000;
      a2_rb_q    <= 10'h000;
      loss_q     <= 1'b0;
      therm_q    <= 1'b0;
      run_loss_q <= 1'b0;
      status_q   <= 4'h0;
      irq_q      <= 1'b0;
    end else begin
      sp_q       <= sp_d;
      fb_q       <= fb_d;
      error_q    <= error_d;
      out_q      <= out_d;
      preset_q   <= force_fw;
      a1_rb_q    <= a1_pct;
      a2_rb_q    <= a2_pct;
      loss_q     <= loss_now | (loss_q & ~fault_rst);
      therm_q    <= therm_now | (therm_q & ~fault_rst);
      run_loss_q <= fmt_run & a2_low;
      status_q   <= status_d;
      irq_q      <= |(status_d & enable_q);
    end
  end

  assign avs_readdata      = rdata_q;
  assign avs_waitrequest   = wait_q;
  assign pi_error          = error_q;
  assign pi_setpoint       = sp_q;
  assign pi_feedback       = fb_q;
  assign pi_out            = out_q;
  assign pi_preset         = preset_q;
  assign standby           = st_q == PPL_ST_STBY;
  assign preset_speed1_sel = run_loss_q;
  assign loop_loss_fault   = loss_q;
  assign thermistor_trip   = therm_q;
  assign relay_out         = relay_q;
  assign irq               = irq_q;

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_wake_full;
    st_q == PPL_ST_STBY && wake_cond && ctrl_q.sense[1];
  endsequence

  a_bus_answer: assert property (req && wait_q |=> !avs_waitrequest)
    else $error("request not answered after one cycle");
  a_err_direct: assert property (!ctrl_q.sense[0] |=>
    pi_error == $past(e_dir)) else $error("direct error sign wrong");
  a_err_inverse: assert property (ctrl_q.sense == PPL_INVERSE |=>
    pi_error == $past(e_inv)) else $error("inverse error sign wrong");
  a_wake_full: assert property (s_wake_full |=>
    pi_out == `PPL_PCT_FULL && pi_preset && !standby) else $error("wake not at full");
  a_sp_digital: assert property (!ctrl_q.sp_src |=>
    pi_setpoint == $past(setpt_q)) else $error("digital setpoint not used");
  a_fb_dcbus: assert property (ctrl_q.fb_src == PPL_FB_DCBUS
    && dc_bus_volts <= `PPL_DC_FULL |=> pi_feedback == $past(dc_bus_volts[9:0]))
    else $error("bus scaling wrong");
  a_fb_diff: assert property (ctrl_q.fb_src == PPL_FB_DIFF && !a1_big
    |=> pi_feedback == 10'h000) else $error("difference not floored");
  a_fb_max: assert property (ctrl_q.fb_src == PPL_FB_MAX |=>
    pi_feedback >= $past(a1_pct) && pi_feedback >= $past(a2_pct)) else $error("max wrong");
  a_loss_trip: assert property (fmt_trip && a2_low |=> loop_loss_fault)
    else $error("loop loss not tripped");
  a_run_loss: assert property (fmt_run && a2_low |=> preset_speed1_sel)
    else $error("preset speed not selected");
  a_therm_trip: assert property (fmt_therm && $stable(ctrl_q)
    && ain2_code > `PPL_THERM_TRIP |-> ##2 thermistor_trip)
    else $error("thermistor trip missing");
  a_stby_entry: assert property ($rose(standby) |->
    $past(stby_time_q) != 10'h000 && $past(at_min_speed)) else $error("bad standby entry");
  a_out_limit: assert property (pi_out <= `PPL_PCT_FULL)
    else $error("output above full scale");
  // Set must beat clear, or an event landing beside a clear would be lost.
  a_loss_sticky: assert property (evt.loss |=> status_q.loss)
    else $error("loss event not latched");
  a_irq_level: assert property ($stable(enable_q) |-> irq == |(status_q & enable_q))
    else $error("interrupt level wrong");
  a_stby_hold: assert property (st_q == PPL_ST_STBY && ctrl_q.pi_mode && stby_en
    && !err_big |=> standby) else $error("left standby on small error");
endmodule : ppl_loop_cfg

/* File: verification/ppl_plant_model.sv */
// Far-side model: the process sensors and a unity-gain PI core.
// Assumes the bench sets sensor levels; every output changes on clk.
`timescale 1ns/10ps
module ppl_plant_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Bench settings
  input  wire logic [11:0] ain1_set,
  input  wire logic [11:0] ain2_set,
  input  wire logic        min_req,
  // From the block
  input  wire logic [11:0] pi_error,
  // To the block
  output logic      [11:0] ain1_code,
  output logic      [11:0] ain2_code,
  output logic      [11:0] motor_current,
  output logic      [11:0] dc_bus_volts,
  output logic             at_min_speed,
  output logic      [11:0] pi_core_out
);
  // The loads are fixed at half of the default rated current and 600 V,
  // so those two feedback sources have exact expected levels.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ain1_code     <= 12'h000;
      ain2_code     <= 12'h000;
      motor_current <= 12'h000;
      dc_bus_volts  <= 12'h000;
      at_min_speed  <= 1'b0;
      pi_core_out   <= 12'h000;
    end else begin
      ain1_code     <= ain1_set;
      ain2_code     <= ain2_set;
      motor_current <= 12'h032;
      dc_bus_volts  <= 12'h258;
      at_min_speed  <= min_req;
      pi_core_out   <= pi_error;
    end
  end
endmodule : ppl_plant_model

/* File: verification/ppl_loop_cfg_tb.sv */
// Self-checking bench of the process loop configuration block.
// Assumes the plant model supplies the process inputs one cycle late.
`timescale 1ns/10ps
`include "ppl_params.svh"
module ppl_loop_cfg_tb;
  import ppl_pkg::*;
  logic clk, reset_n, min_req, avs_waitrequest, pi_preset, standby;
  logic preset_speed1_sel, loop_loss_fault, thermistor_trip, relay_out, irq;
  logic at_min_speed;
  logic [31:0] avs_readdata;
  logic [11:0] ain1_set, ain2_set, ain1_code, ain2_code, motor_current;
  logic [11:0] dc_bus_volts, pi_core_out, pi_error;
  logic [9:0]  pi_setpoint, pi_feedback, pi_out;
  ppl_avmm_req_t avs;
  int failures = 0;
  int checks = 0;

  ppl_loop_cfg #(.TICK_CYCLES(4)) dut (.clk(clk), .reset_n(reset_n), .avs(avs),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ain1_code(ain1_code), .ain2_code(ain2_code), .motor_current(motor_current),
    .dc_bus_volts(dc_bus_volts), .at_min_speed(at_min_speed),
    .pi_core_out(pi_core_out), .pi_error(pi_error), .pi_setpoint(pi_setpoint),
    .pi_feedback(pi_feedback), .pi_out(pi_out), .pi_preset(pi_preset),
    .standby(standby), .preset_speed1_sel(preset_speed1_sel),
    .loop_loss_fault(loop_loss_fault), .thermistor_trip(thermistor_trip),
    .relay_out(relay_out), .irq(irq));

  ppl_plant_model u_plant (.clk(clk), .reset_n(reset_n), .ain1_set(ain1_set),
    .ain2_set(ain2_set), .min_req(min_req), .pi_error(pi_error),
    .ain1_code(ain1_code), .ain2_code(ain2_code), .motor_current(motor_current),
    .dc_bus_volts(dc_bus_volts), .at_min_speed(at_min_speed),
    .pi_core_out(pi_core_out));

  task automatic end_sim;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One bus cycle; the request stands until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs <= '{address: a, read: !wr, write: wr, writedata: d};
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs <= '0;
    if (n >= 20) begin
      failures++;
      end_sim();
    end
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rdc(input string what, input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(what, q, exp);
  endtask : rdc

  // Covers the model delay plus the two-stage trip and relay paths.
  task automatic settle;
    repeat (4) @(posedge clk);
  endtask : settle

  function automatic logic [31:0] cw(int f, int s, int p, int n, int m);
    return {22'h0, f[2:0], s[2:0], p[0], n[1:0], m[0]};
  endfunction : cw

  task automatic t_reset;
    rdc("ctrl", `PPL_REG_CTRL, 32'h0);
    rdc("setpt", `PPL_REG_SETPT, 32'h0);
    rdc("stby", `PPL_REG_STBY, 32'h0);
    rdc("wake", `PPL_REG_WAKE, 32'h32);
    rdc("relay", `PPL_REG_RELAY, 32'h0);
    rdc("unmapped", 6'h3c, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_fbk;
    logic [9:0] exp [6] = '{10'h0c8, 10'h320, 10'h1f4, 10'h258, 10'h258, 10'h320};
    ain1_set <= 12'hccc;
    ain2_set <= 12'h333;
    for (int s = 0; s < 6; s++) begin
      wr(`PPL_REG_CTRL, cw(0, s, 0, 0, 0));
      settle();
      chk("feedback", 32'(pi_feedback), 32'(exp[s]));
    end
    wr(`PPL_REG_CTRL, cw(0, 4, 0, 0, 0));
    ain1_set <= 12'h333;
    ain2_set <= 12'hccc;
    settle();
    chk("negative diff", 32'(pi_feedback), 32'h0);
    wr(`PPL_REG_CTRL, cw(1, 0, 0, 0, 0));
    settle();
    chk("ain2 current", 32'(pi_feedback), 32'h320);
    $display("test feedback done");
  endtask : t_fbk

  task automatic t_sense;
    logic [11:0] e [2] = '{12'h12c, 12'hed4};
    logic [9:0]  o [2] = '{10'h12c, 10'h000};
    ain1_set <= 12'hccc;
    ain2_set <= 12'h333;
    wr(`PPL_REG_SETPT, 32'h1f4);
    for (int n = 0; n < 2; n++) begin
      wr(`PPL_REG_CTRL, cw(0, 0, 0, n, 0));
      settle();
      chk("setpoint", 32'(pi_setpoint), 32'h1f4);
      chk("error", 32'(pi_error), 32'(e[n]));
      chk("output", 32'(pi_out), 32'(o[n]));
    end
    wr(`PPL_REG_CTRL, cw(0, 0, 1, 0, 0));
    settle();
    chk("analog setpoint", 32'(pi_setpoint), 32'h320);
    $display("test sense done");
  endtask : t_sense

  task automatic t_loss;
    wr(`PPL_REG_ENABLE, 32'h1);
    for (int f = 2; f < 6; f++) begin
      wr(`PPL_REG_CTRL, cw(f, 0, 0, 0, 0));
      ain2_set <= 12'h100;
      settle();
      chk("loss fault", 32'(loop_loss_fault), 32'(f % 2 == 0));
      chk("preset speed", 32'(preset_speed1_sel), 32'(f % 2));
      chk("loss irq", 32'(irq), 32'(f % 2 == 0));
      ain2_set <= 12'h333;
      wr(`PPL_REG_CMD, 32'h1);
      wr(`PPL_REG_CLEAR, 32'hf);
      settle();
      chk("loss released", 32'(loop_loss_fault), 32'h0);
      chk("irq cleared", 32'(irq), 32'h0);
    end
    wr(`PPL_REG_ENABLE, 32'h0);
    $display("test loss done");
  endtask : t_loss

  task automatic t_therm;
    logic [11:0] r [4] = '{12'h5dc, 12'h5dd, 12'h4b0, 12'h3e8};
    logic        t [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    wr(`PPL_REG_CTRL, cw(6, 0, 0, 0, 0));
    for (int i = 0; i < 4; i++) begin
      ain2_set <= r[i];
      settle();
      wr(`PPL_REG_CMD, 32'h1);
      settle();
      chk("thermistor trip", 32'(thermistor_trip), 32'(t[i]));
    end
    ain2_set <= 12'h333;
    wr(`PPL_REG_CLEAR, 32'hf);
    $display("test thermistor done");
  endtask : t_therm

  task automatic t_stby;
    int n;
    logic [31:0] q;
    for (int s = 2; s < 4; s++) begin
      wr(`PPL_REG_CTRL, cw(0, 0, 0, s, 1));
      wr(`PPL_REG_SETPT, 32'hc8);
      wr(`PPL_REG_STBY, 32'h3);
      min_req <= 1'b1;
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (standby !== 1'b1 && n < 40);
      chk("dwell", 32'(n >= 12 && n <= 16), 32'h1);
      bus(1'b0, `PPL_REG_STATUS, 32'h0, q);
      chk("standby status", 32'(q[2]), 32'h1);
      min_req <= 1'b0;
      wr(`PPL_REG_SETPT, s == 2 ? 32'hfa : 32'h96);
      settle();
      chk("small error", 32'(standby), 32'h1);
      wr(`PPL_REG_SETPT, s == 2 ? 32'h12c : 32'h64);
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (pi_preset !== 1'b1 && n < 10);
      chk("wake output", 32'(pi_out), 32'h3e8);
      settle();
      chk("awake", 32'(standby), 32'h0);
      wr(`PPL_REG_STBY, 32'h0);
      wr(`PPL_REG_CLEAR, 32'hf);
    end
    $display("test standby done");
  endtask : t_stby

  task automatic t_relay;
    logic [11:0] a [4] = '{12'h800, 12'h999, 12'h733, 12'h666};
    logic        y [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    ain1_set <= 12'h000;
    wr(`PPL_REG_CTRL, cw(0, 1, 0, 0, 0));
    wr(`PPL_REG_RELAY, 32'h006401f4);
    for (int i = 0; i < 4; i++) begin
      ain1_set <= a[i];
      settle();
      chk("relay", 32'(relay_out), 32'(y[i]));
    end
    $display("test relay done");
  endtask : t_relay

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    reset_n = 1'b0;
    avs = '0;
    ain1_set = 12'h000;
    ain2_set = 12'h333;
    min_req = 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_fbk();
    t_sense();
    t_loss();
    t_therm();
    t_stby();
    t_relay();
    end_sim();
  end

  // A hang anywhere is cut short well inside the cycle budget.
  initial begin
    #500000;
    failures++;
    end_sim();
  end
endmodule : ppl_loop_cfg_tb
